//--- inc/pam_consts.vh
/*
 * constants for the port a pin multiplexer: register byte offsets,
 * reset values, key values and alternate function select codes.
 * assumes inclusion by bare name from the design files.
 */
`ifndef PAM_CONSTS_VH
`define PAM_CONSTS_VH

// register byte offsets on the wishbone slave (word aligned)
`define PAM_OFS_DATA      6'h00
`define PAM_OFS_DIR       6'h04
`define PAM_OFS_OPT       6'h08
`define PAM_OFS_ALT       6'h0c
`define PAM_OFS_KEY_FIRST 6'h10
`define PAM_OFS_KEY_SECND 6'h14
`define PAM_OFS_KEY_THIRD 6'h18
`define PAM_OFS_STATUS    6'h1c

// reset values
`define PAM_RST_DATA      6'h00
`define PAM_RST_DIR       6'h08
`define PAM_RST_OPT       6'h02
`define PAM_RST_ALT       12'h000
`define PAM_RST_OE_N      6'h3f
`define PAM_RST_PU        6'h0a

// strap counter value at which the synchronised strap is trusted
`define PAM_STRAP_WAIT    2'h2

// reset multiplexing key values
`define PAM_KEY_FIRST_VAL 8'h55
`define PAM_KEY_SECND_VAL 8'haa

// per-line alternate select codes (two bits per line)
`define PAM_SEL_GPIO      2'h0
`define PAM_SEL_ANALOG    2'h1
`define PAM_SEL_ALT1      2'h2
`define PAM_SEL_ALT2      2'h3

// status register field positions
`define PAM_ST_RSTFN_BIT  8
`define PAM_ST_PKG16_BIT  9
`define PAM_ST_ICC_BIT    10

`endif

//--- logic/pam_sync.v
/*
 * two flip-flop synchroniser for a vector of pin levels.
 * assumes each bit is an independent level; no bus coherency is given.
 */
`timescale 1ns/1ps
module pam_sync #(
    parameter W   = 1,
    parameter RST = 1'b0
) (
    input  wire         mclk_i,
    input  wire         nrst_i,
    input  wire [W-1:0] async_i,
    output wire [W-1:0] sync_o
);

    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    // first stage feeds only the second stage
    always @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            meta_q <= {W{RST}};
            sync_q <= {W{RST}};
        end
        else
        begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;

endmodule

//--- logic/pam_key.v
/*
 * two-byte key sequencer that releases the reset function of the shared
 * reset/line 3 pin. assumes one-cycle write strobes from the register slave.
 */
`timescale 1ns/1ps
`include "pam_consts.vh"
module pam_key (
    input  wire       mclk_i,
    input  wire       nrst_i,
    input  wire       lock_i,
    input  wire       wr_first_i,
    input  wire       wr_second_i,
    input  wire       wr_other_i,
    input  wire [7:0] wdata_i,
    output wire       released_o
);

    localparam ST_IDLE = 3'b001;
    localparam ST_ARM  = 3'b010;
    localparam ST_DONE = 3'b100;

    reg [2:0] state_q;
    reg [2:0] state_d;

    // next state; done is sticky until the next reset
    always @*
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:
            begin
                if (wr_first_i && !lock_i && wdata_i == `PAM_KEY_FIRST_VAL)
                    state_d = ST_ARM;
            end
            ST_ARM:
            begin
                if (wr_second_i && wdata_i == `PAM_KEY_SECND_VAL)
                    state_d = ST_DONE;
                else if (wr_first_i && wdata_i == `PAM_KEY_FIRST_VAL)
                    state_d = ST_ARM;
                else if (wr_first_i || wr_second_i || wr_other_i)
                    state_d = ST_IDLE;
            end
            ST_DONE:
                state_d = ST_DONE;
            default:
                state_d = ST_IDLE;
        endcase
        if (lock_i && state_q != ST_DONE)
            state_d = ST_IDLE;
    end

    always @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            state_q <= ST_IDLE;
        else
            state_q <= state_d;
    end

    assign released_o = (state_q == ST_DONE) && !lock_i;

endmodule

//--- logic/pam_top.v
/*
 * port a pin multiplexer: six port lines, their alternate functions,
 * the shared reset/line 3 pin with its key release, and the 16-pin variant.
 * assumes a classic wishbone master on mclk_i, pads outside that resolve
 * in/out/oe_n triples (oe_n low = this block drives), and a package strap.
 */
// What this block does
// - after reset line 3 pin is reset input
// - keys 55h then AAh release reset function
// - 16-pin: line 3 always output, keys ignored
// - 16-pin: reset comes from dedicated pin
// - 16-pin: in-circuit clock/data on dedicated pins
// - reset returns line 1 to pulled-up input
// - reset-state pin setup held during reset
// - line 0: analog 0, pwm, in-circuit data
// - line 2: analog 2, capture input
// - line 4: analog 3, main clock out
// - line 5: analog 4, external clock in
// - line 1: analog 1, in-circuit clock
`timescale 1ns/1ps
`include "pam_consts.vh"
module pam_top (
    input  wire        mclk_i,
    input  wire        nrst_i,
    // classic wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [5:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output wire [31:0] wb_dat_o,
    output wire        wb_ack_o,
    // package strap: high on the 16-pin variant
    input  wire        pkg16_i,
    // port line pads, bit n = line n
    input  wire [5:0]  pad_in_i,
    output wire [5:0]  pad_out_o,
    output wire [5:0]  pad_oe_n_o,
    output wire [5:0]  pad_pu_o,
    // dedicated pads of the 16-pin variant
    input  wire        rst_pad_n_i,
    input  wire        icc_clk_pad_i,
    input  wire        icc_data_pad_i,
    output wire        icc_data_pad_o,
    output wire        icc_data_pad_oe_n_o,
    // on-chip peripherals
    input  wire        icc_mode_i,
    input  wire        icc_data_out_i,
    input  wire        icc_data_oe_i,
    input  wire        pwm_out_i,
    input  wire        mclk_out_i,
    output wire [4:0]  analog_en_o,
    output wire        icc_clk_o,
    output wire        icc_data_o,
    output wire        capture_o,
    output wire        ext_clk_o,
    output wire        rst_req_n_o,
    output wire        rst_fn_o
);

    // ------------------------------------------------------------------
    // pin synchronisers: every pad level passes two flops first
    wire [5:0] pad_s;
    wire [3:0] ded_s;
    wire       rst_pad_s;
    wire       icc_clk_s;
    wire       icc_dat_s;
    wire       pkg16_s;

    pam_sync #(.W(6), .RST(1'b1)) u_sync_pad (
        .mclk_i  (mclk_i),
        .nrst_i  (nrst_i),
        .async_i (pad_in_i),
        .sync_o  (pad_s)
    );

    // dedicated pads idle high so a reset does not look like a request
    pam_sync #(.W(4), .RST(1'b1)) u_sync_ded (
        .mclk_i  (mclk_i),
        .nrst_i  (nrst_i),
        .async_i ({pkg16_i, icc_data_pad_i, icc_clk_pad_i, rst_pad_n_i}),
        .sync_o  (ded_s)
    );

    assign rst_pad_s = ded_s[0];
    assign icc_clk_s = ded_s[1];
    assign icc_dat_s = ded_s[2];
    assign pkg16_s   = ded_s[3];

    // ------------------------------------------------------------------
    // strap capture: taken once after release, held until next reset.
    // until then the 8-pin behaviour (reset pin) stands, which is safe.
    reg pkg16_q;
    reg strap_done_q;
    reg [1:0] strap_cnt_q;

    always @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            pkg16_q      <= 1'b0;
            strap_done_q <= 1'b0;
            strap_cnt_q  <= 2'h0;
        end
        else if (!strap_done_q)
        begin
            // wait for the synchroniser to fill before trusting it
            strap_cnt_q <= strap_cnt_q + 2'h1;
            if (strap_cnt_q == `PAM_STRAP_WAIT)
            begin
                pkg16_q      <= pkg16_s;
                strap_done_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // wishbone slave: ack one cycle after the request, write at ack edge
    reg        ack_q;
    reg [31:0] rdat_q;
    reg [5:0]  data_q;
    reg [5:0]  dir_q;
    reg [5:0]  opt_q;
    reg [11:0] alt_q;
    reg [31:0] rdat_d;

    wire req    = wb_cyc_i && wb_stb_i;
    wire wr_hit = req && ack_q && wb_we_i && wb_sel_i[0];
    wire [7:0] wbyte = wb_dat_i[7:0];

    wire wr_data  = wr_hit && (wb_adr_i == `PAM_OFS_DATA);
    wire wr_dir   = wr_hit && (wb_adr_i == `PAM_OFS_DIR);
    wire wr_opt   = wr_hit && (wb_adr_i == `PAM_OFS_OPT);
    wire wr_alt   = wr_hit && (wb_adr_i == `PAM_OFS_ALT);
    wire wr_key1  = wr_hit && (wb_adr_i == `PAM_OFS_KEY_FIRST);
    wire wr_key2  = wr_hit && (wb_adr_i == `PAM_OFS_KEY_SECND);
    wire wr_key3  = wr_hit && (wb_adr_i == `PAM_OFS_KEY_THIRD);
    // any other register write breaks a pending key sequence
    wire wr_other = wr_hit && !wr_key1 && !wr_key2;

    wire rst_fn;

    // alt register needs both low bytes; upper lane gated separately
    always @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h00000000;
            data_q <= `PAM_RST_DATA;
            // line 1 back to input with pull-up
            dir_q  <= `PAM_RST_DIR;
            opt_q  <= `PAM_RST_OPT;
            alt_q  <= `PAM_RST_ALT;
        end
        else
        begin
            ack_q <= req && !ack_q;
            if (req && !ack_q)
                rdat_q <= rdat_d;
            if (wr_data)
                data_q <= wbyte[5:0];
            if (wr_dir)
                dir_q <= wbyte[5:0];
            if (wr_opt)
                opt_q <= wbyte[5:0];
            if (wr_alt)
                alt_q[7:0] <= wbyte;
            if (wr_alt && wb_sel_i[1])
                alt_q[11:8] <= wb_dat_i[11:8];
        end
    end

    // read mux; unmapped offsets and the key registers read as zero
    always @*
    begin
        rdat_d = 32'h00000000;
        case (wb_adr_i)
            `PAM_OFS_DATA:   rdat_d[5:0]  = data_q;
            `PAM_OFS_DIR:    rdat_d[5:0]  = dir_q;
            `PAM_OFS_OPT:    rdat_d[5:0]  = opt_q;
            `PAM_OFS_ALT:    rdat_d[11:0] = alt_q;
            `PAM_OFS_STATUS:
            begin
                rdat_d[5:0]              = pad_s;
                rdat_d[`PAM_ST_RSTFN_BIT] = rst_fn;
                rdat_d[`PAM_ST_PKG16_BIT] = pkg16_q;
                rdat_d[`PAM_ST_ICC_BIT]   = icc_mode_i;
            end
            default:         rdat_d = 32'h00000000;
        endcase
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    // ------------------------------------------------------------------
    // key sequencer; a write to the third key register breaks a pending sequence
    wire released;

    pam_key u_key (
        .mclk_i      (mclk_i),
        .nrst_i      (nrst_i),
        .lock_i      (pkg16_q),
        .wr_first_i  (wr_key1),
        .wr_second_i (wr_key2),
        .wr_other_i  (wr_other | wr_key3),
        .wdata_i     (wbyte),
        .released_o  (released)
    );

    // shared pin is reset until released, never in 16-pin form
    assign rst_fn = !pkg16_q && !released;

    // ------------------------------------------------------------------
    // line select decode, used for every line except line 3
    function [1:0] sel_of;
        input [11:0] alt;
        input integer line;
        begin
            sel_of = alt[line*2 +: 2];
        end
    endfunction

    wire [1:0] sel0 = sel_of(alt_q, 0);
    wire [1:0] sel1 = sel_of(alt_q, 1);
    wire [1:0] sel2 = sel_of(alt_q, 2);
    wire [1:0] sel4 = sel_of(alt_q, 4);
    wire [1:0] sel5 = sel_of(alt_q, 5);

    // in-circuit signals on port lines only in 8-pin form
    wire icc_on_port = icc_mode_i && !pkg16_q;

    // analog enables isolate the digital buffer from the pad
    wire an0 = (sel0 == `PAM_SEL_ANALOG) && !icc_on_port;
    wire an1 = (sel1 == `PAM_SEL_ANALOG) && !icc_on_port;
    wire an2 = (sel2 == `PAM_SEL_ANALOG);
    wire an3 = (sel4 == `PAM_SEL_ANALOG);
    wire an4 = (sel5 == `PAM_SEL_ANALOG);

    assign analog_en_o = {an4, an3, an2, an1, an0};

    // ------------------------------------------------------------------
    // pad drive, registered so data outputs come from flops
    reg [5:0] out_q;
    reg [5:0] oe_n_q;
    reg [5:0] pu_q;
    reg [5:0] out_d;
    reg [5:0] oe_n_d;
    reg [5:0] pu_d;

    always @*
    begin
        out_d  = data_q;
        oe_n_d = ~dir_q;
        pu_d   = opt_q & ~dir_q;
        // line 0 pwm or in-circuit data
        if (icc_on_port)
        begin
            out_d[0]  = icc_data_out_i;
            oe_n_d[0] = !icc_data_oe_i;
            pu_d[0]   = !icc_data_oe_i;
        end
        else if (an0)
        begin
            oe_n_d[0] = 1'b1;
            pu_d[0]   = 1'b0;
        end
        else if (sel0 == `PAM_SEL_ALT1)
        begin
            out_d[0]  = pwm_out_i;
            oe_n_d[0] = 1'b0;
        end
        // line 1 in-circuit clock is an input
        if (icc_on_port)
        begin
            oe_n_d[1] = 1'b1;
            pu_d[1]   = 1'b1;
        end
        else if (an1)
        begin
            oe_n_d[1] = 1'b1;
            pu_d[1]   = 1'b0;
        end
        // line 2 analog or capture input
        if (an2 || sel2 == `PAM_SEL_ALT1)
        begin
            oe_n_d[2] = 1'b1;
            pu_d[2]   = an2 ? 1'b0 : pu_d[2];
        end
        // line 3 forced output in 16-pin form
        if (pkg16_q)
            oe_n_d[3] = 1'b0;
        // reset function: pad is an input, pulled up
        if (rst_fn)
        begin
            oe_n_d[3] = 1'b1;
            pu_d[3]   = 1'b1;
        end
        else
            pu_d[3] = 1'b0;
        if (an3)
        begin
            oe_n_d[4] = 1'b1;
            pu_d[4]   = 1'b0;
        end
        else if (sel4 == `PAM_SEL_ALT1)
        begin
            out_d[4]  = mclk_out_i;
            oe_n_d[4] = 1'b0;
        end
        if (an4 || sel5 == `PAM_SEL_ALT1)
        begin
            oe_n_d[5] = 1'b1;
            pu_d[5]   = an4 ? 1'b0 : pu_d[5];
        end
    end

    // reset-state pad setup held through reset
    always @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            out_q  <= 6'h00;
            oe_n_q <= `PAM_RST_OE_N;
            // line 1 pulled up; line 3 pulled up as reset input
            pu_q   <= `PAM_RST_PU;
        end
        else
        begin
            out_q  <= out_d;
            oe_n_q <= oe_n_d;
            pu_q   <= pu_d;
        end
    end

    assign pad_out_o  = out_q;
    assign pad_oe_n_o = oe_n_q;
    assign pad_pu_o   = pu_q;

    // ------------------------------------------------------------------
    // in-circuit signals and dedicated data pad
    reg icc_dat_out_q;
    reg icc_dat_oe_n_q;

    // dedicated data pad drives only in 16-pin form
    always @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            icc_dat_out_q  <= 1'b0;
            icc_dat_oe_n_q <= 1'b1;
        end
        else
        begin
            icc_dat_out_q  <= icc_data_out_i;
            icc_dat_oe_n_q <= !(pkg16_q && icc_mode_i && icc_data_oe_i);
        end
    end

    assign icc_data_pad_o      = icc_dat_out_q;
    assign icc_data_pad_oe_n_o = icc_dat_oe_n_q;

    // idle-high clock relies on board pull-up
    // clock and data source by package
    assign icc_clk_o  = pkg16_q ? icc_clk_s : pad_s[1];
    assign icc_data_o = pkg16_q ? icc_dat_s : pad_s[0];

    assign capture_o = (sel2 == `PAM_SEL_ALT1) ? pad_s[2] : 1'b0;
    // external clock from line 5; synchronised, so slow clocks only
    assign ext_clk_o = (sel5 == `PAM_SEL_ALT1) ? pad_s[5] : 1'b0;

    // ------------------------------------------------------------------
    // reset request towards the reset manager, active low
    reg rst_req_n_q;

    always @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            rst_req_n_q <= 1'b1;
        else if (pkg16_q)
            rst_req_n_q <= rst_pad_s;
        // 8-pin reset taken from line 3 pad
        else if (rst_fn)
            rst_req_n_q <= pad_s[3];
        else
            rst_req_n_q <= 1'b1;
    end

    assign rst_req_n_o = rst_req_n_q;
    assign rst_fn_o    = rst_fn;

endmodule

//--- tb/pam_top_monitor.sv
/* assertion checker for the port a pin multiplexer top.
   assumes it is bound into pam_top and sees only that module's ports. */
`timescale 1ns/1ps
`include "pam_consts.vh"
module pam_top_monitor (
    input wire        mclk_i,
    input wire        nrst_i,
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_we_i,
    input wire [5:0]  wb_adr_i,
    input wire [3:0]  wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire        wb_ack_o,
    input wire        pkg16_i,
    input wire [5:0]  pad_in_i,
    input wire [5:0]  pad_oe_n_o,
    input wire [5:0]  pad_pu_o,
    input wire        rst_pad_n_i,
    input wire        icc_clk_pad_i,
    input wire [4:0]  analog_en_o,
    input wire        icc_clk_o,
    input wire        rst_req_n_o,
    input wire        rst_fn_o
);
    default clocking mon_cb @(posedge mclk_i);
    endclocking
    default disable iff (!nrst_i);

    // second key value written, seen at the edge that completes it
    wire key2_wr = wb_ack_o & wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0]
        & (wb_adr_i == `PAM_OFS_KEY_SECND) & (wb_dat_i[7:0] == `PAM_KEY_SECND_VAL);

    a_rstfn_on_entry: assert property ($rose(nrst_i) |-> rst_fn_o)
        else $error("shared pin not in reset use");
    a_pin_reset_req: assert property (
        (!pkg16_i && rst_fn_o && !pad_in_i[3]) [*4] |-> !rst_req_n_o)
        else $error("shared pin low gave no reset request");
    a_key_release: assert property (
        $fell(rst_fn_o) && !pkg16_i |-> $past(key2_wr) || $past(key2_wr, 2))
        else $error("reset use left without key");
    a_release_sticky: assert property (!rst_fn_o |=> !rst_fn_o)
        else $error("reset use came back");
    a_line3_out: assert property ((pkg16_i && !rst_fn_o) [*2] |-> !pad_oe_n_o[3])
        else $error("line 3 not driven on 16-pin part");
    a_ded_reset: assert property (
        (pkg16_i && !rst_fn_o && $stable(rst_pad_n_i)) [*5] |-> rst_req_n_o == rst_pad_n_i)
        else $error("reset request not from dedicated pad");
    a_ded_clock: assert property (
        (pkg16_i && !rst_fn_o && $stable(icc_clk_pad_i)) [*4] |-> icc_clk_o == icc_clk_pad_i)
        else $error("comm clock not from dedicated pad");
    a_reset_pins: assert property (
        $rose(nrst_i) |-> pad_oe_n_o == 6'h3f && pad_pu_o == 6'h0a)
        else $error("pins not in reset state");
    a_analog_line4: assert property (
        analog_en_o[3] [*2] |-> pad_oe_n_o[4] && !pad_pu_o[4])
        else $error("line 4 driven while analog");
    a_analog_line5: assert property (
        analog_en_o[4] [*2] |-> pad_oe_n_o[5] && !pad_pu_o[5])
        else $error("line 5 driven while analog");
endmodule
bind pam_top pam_top_monitor pam_top_monitor_i (
    .mclk_i, .nrst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_ack_o, .pkg16_i, .pad_in_i, .pad_oe_n_o, .pad_pu_o, .rst_pad_n_i,
    .icc_clk_pad_i, .analog_en_o, .icc_clk_o, .rst_req_n_o, .rst_fn_o);

//--- tb/pam_board.sv
/* board model: resolves each pad from the block's drive, pull-ups and board
   drivers. assumes bit 6 is the dedicated data pad, bits 5..0 the port lines. */
`timescale 1ns/1ps
module pam_board (
    input  wire       mclk_i,
    input  wire [6:0] drv_i,
    input  wire [6:0] oe_n_i,
    input  wire [6:0] pu_i,
    input  wire [6:0] ext_en_i,
    input  wire [6:0] ext_val_i,
    output wire [6:0] lvl_o
);
    reg [6:0] junk_q = 7'h55;

    // a floating line flips every cycle, so no stale level can pass
    always @(posedge mclk_i)
        junk_q <= ~junk_q;

    // board pull-up holds the comm clock line high
    assign lvl_o = ~oe_n_i & drv_i
        | oe_n_i & (ext_en_i & ext_val_i | ~ext_en_i & (pu_i | 7'h02 | junk_q));
endmodule

//--- tb/pam_top_tb_top.sv
/* self-checking bench for the port a pin multiplexer.
   assumes the board model on the pads and the checker bound into pam_top. */
`timescale 1ns/1ps
`include "pam_consts.vh"
module pam_top_tb_top;
    logic        mclk_i = 1'b0, nrst_i = 1'b0, pkg16_i = 1'b0;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [5:0]  wb_adr_i = 6'h00;
    logic [3:0]  wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0, r, e;
    logic        rst_pad_n_i = 1'b1, icc_clk_pad_i = 1'b1, icc_mode_i = 1'b0;
    logic        icc_data_out_i = 1'b0, icc_data_oe_i = 1'b0, pwm_out_i = 1'b0;
    logic        mclk_out_i = 1'b0;
    logic [6:0]  ext_en = 7'h7d, ext_val = 7'h7f;
    wire  [6:0]  lvl;
    wire  [31:0] wb_dat_o;
    wire  [5:0]  pad_out_o, pad_oe_n_o, pad_pu_o;
    wire  [4:0]  analog_en_o;
    wire         wb_ack_o, icc_data_pad_o, icc_data_pad_oe_n_o, icc_clk_o, icc_data_o;
    wire         capture_o, ext_clk_o, rst_req_n_o, rst_fn_o;
    int          fails = 0, cmp_count = 0, seed = 9801;
    logic [31:0] exp_q[$];
    logic [13:0] kt[12] = '{14'h1055, 14'h145a, 14'h14aa, 14'h1055, 14'h0000, 14'h14aa,
                            14'h1055, 14'h1800, 14'h14aa, 14'h1055, 14'h1055, 14'h14aa};

    pam_top pam_top_i (
        .mclk_i, .nrst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .pkg16_i, .pad_in_i(lvl[5:0]), .pad_out_o,
        .pad_oe_n_o, .pad_pu_o, .rst_pad_n_i, .icc_clk_pad_i, .icc_data_pad_i(lvl[6]),
        .icc_data_pad_o, .icc_data_pad_oe_n_o, .icc_mode_i, .icc_data_out_i, .icc_data_oe_i,
        .pwm_out_i, .mclk_out_i, .analog_en_o, .icc_clk_o, .icc_data_o, .capture_o,
        .ext_clk_o, .rst_req_n_o, .rst_fn_o);
    pam_board pam_board_i (
        .mclk_i, .drv_i({icc_data_pad_o, pad_out_o}), .oe_n_i({icc_data_pad_oe_n_o, pad_oe_n_o}),
        .pu_i({1'b0, pad_pu_o}), .ext_en_i(ext_en), .ext_val_i(ext_val), .lvl_o(lvl));

    // 125 mhz system clock
    initial
    begin
        forever #4 mclk_i = ~mclk_i;
    end

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] ex);
        cmp_count++;
        if (seen !== ex)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, ex, seen);
        end
    endtask

    task automatic cy(input int n);
        repeat (n) @(posedge mclk_i);
    endtask

    // one classic cycle; held until ack is sampled, bounded wait
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge mclk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
        do
            @(posedge mclk_i);
        while (wb_ack_o !== 1'b1 && ++n < 9);
        // a missing ack ends the run at once, as a failure
        if (n == 9)
        begin
            fails++;
            final_report();
        end
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask

    task automatic rd(input logic [5:0] a, input logic [31:0] ex);
        exp_q.push_back(ex);
        bus(1'b0, a, 32'h0);
    endtask

    task automatic do_rst(input logic pk);
        @(posedge mclk_i);
        nrst_i <= 1'b0;
        pkg16_i <= pk;
        cy(10);
        check("oe_n", pad_oe_n_o, 6'h3f);
        check("pull-up", pad_pu_o, 6'h0a);
        check("rst_fn", rst_fn_o, 1'b1);
        nrst_i <= 1'b1;
        cy(6);
    endtask

    task automatic final_report;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // read data is matched against the oldest noted read
    always @(posedge mclk_i)
        if (wb_ack_o === 1'b1 && wb_cyc_i && !wb_we_i)
            check("read data", wb_dat_o, exp_q.pop_front());

    // watchdog: the sequence needs well under two thousand cycles
    initial
    begin
        cy(20000);
        fails++;
        final_report();
    end

    initial
    begin
        do_rst(1'b0);
        r = $random(seed);
        ext_val <= r[6:0] | 7'h08;
        cy(3);
        rd(`PAM_OFS_DIR, 32'h8);
        rd(`PAM_OFS_OPT, 32'h2);
        rd(`PAM_OFS_ALT, 32'h0);
        rd(6'h20, 32'h0);
        // status: reset use in bit 8, pad levels in the low bits
        rd(`PAM_OFS_STATUS, {21'h0, 3'h1, 2'h0, r[5:0] | 6'h0a});
        // low shared pin asks for reset
        ext_val[3] <= 1'b0;
        cy(5);
        check("rst_req_n", rst_req_n_o, 1'b0);
        ext_val[3] <= 1'b1;
        $display("test reset state done");
        // wrong sequences keep reset use, the last one releases it
        foreach (kt[i])
        begin
            bus(1'b1, kt[i][13:8], {24'h0, kt[i][7:0]});
            if (i % 3 == 2)
            begin
                cy(2);
                check("rst_fn", rst_fn_o, i < 11);
            end
        end
        // released pin is port line 3; low level no longer resets
        bus(1'b1, `PAM_OFS_DATA, 32'h08);
        cy(2);
        check("line 3", {pad_oe_n_o[3], pad_out_o[3]}, 2'b01);
        bus(1'b1, `PAM_OFS_DATA, 32'h00);
        bus(1'b1, `PAM_OFS_DIR, 32'h0a);
        cy(5);
        check("rst_req_n", rst_req_n_o, 1'b1);
        check("line 1 oe_n", pad_oe_n_o[1], 1'b0);
        $display("test key release done");
        do_rst(1'b0);
        rd(`PAM_OFS_DIR, 32'h8);
        bus(1'b1, `PAM_OFS_DIR, 32'h11);
        bus(1'b1, `PAM_OFS_ALT, 32'ha22);
        ext_en <= 7'h7f;
        repeat (6)
        begin
            r = $random(seed);
            {pwm_out_i, mclk_out_i} <= r[1:0];
            ext_val <= r[14:8] | 7'h08;
            cy(4);
            check("pwm pad", pad_out_o[0], r[1]);
            check("clock out pad", pad_out_o[4], r[0]);
            check("capture", capture_o, r[10]);
            check("ext clock", ext_clk_o, r[13]);
            check("comm clock", icc_clk_o, r[9]);
        end
        ext_en <= 7'h7d;
        bus(1'b1, `PAM_OFS_ALT, 32'h515);
        cy(2);
        check("analog", analog_en_o, 5'h1f);
        check("oe_n", pad_oe_n_o, 6'h3f);
        check("pull-up", pad_pu_o, 6'h08);
        bus(1'b1, `PAM_OFS_ALT, 32'h0);
        {icc_mode_i, icc_data_oe_i, icc_data_out_i} <= {2'b11, r[3]};
        cy(3);
        // comm data on line 0 both ways
        check("comm data pad", {pad_oe_n_o[0], pad_out_o[0]}, {1'b0, r[3]});
        icc_data_oe_i <= 1'b0;
        cy(4);
        check("comm data in", icc_data_o, ext_val[0]);
        icc_mode_i <= 1'b0;
        $display("test alternates done");
        do_rst(1'b1);
        bus(1'b1, `PAM_OFS_KEY_FIRST, 32'h55);
        bus(1'b1, `PAM_OFS_KEY_SECND, 32'haa);
        bus(1'b1, `PAM_OFS_DIR, 32'h00);
        cy(3);
        // 16-pin: line 3 always driven, reset on its own pad
        check("line 3 oe_n", pad_oe_n_o[3], 1'b0);
        check("rst_fn", rst_fn_o, 1'b0);
        // status: package flag in bit 9, line 3 driven low
        rd(`PAM_OFS_STATUS, {21'h0, 3'h2, 2'h0, ext_val[5:0] & 6'h37 | 6'h02});
        rst_pad_n_i <= 1'b0;
        cy(5);
        check("rst_req_n", rst_req_n_o, 1'b0);
        rst_pad_n_i <= 1'b1;
        cy(5);
        check("rst_req_n", rst_req_n_o, 1'b1);
        repeat (4)
        begin
            r = $random(seed);
            {icc_clk_pad_i, ext_val[6], icc_data_oe_i, icc_data_out_i} <= r[3:0];
            icc_mode_i <= 1'b1;
            cy(4);
            check("comm clock", icc_clk_o, r[3]);
            check("data pad oe_n", icc_data_pad_oe_n_o, !r[1]);
            check("comm data", icc_data_o, r[1] ? r[0] : r[2]);
            check("line 0 oe_n", pad_oe_n_o[0], 1'b1);
        end
        // comm mode shows in status, port lines untouched by it
        rd(`PAM_OFS_STATUS, {21'h0, 3'h6, 2'h0, ext_val[5:0] & 6'h37 | 6'h02});
        $display("test 16-pin done");
        final_report();
    end
endmodule
